// [core/ufx_pkg.sv]
// shared constants and state encodings for the serial extension block
package ufx_pkg;
  localparam int DATA_W        = 8;   // data bits per frame
  localparam int ADDR_W        = 4;   // node address field width
  localparam int ADDR_MARK_BIT = 7;   // msb marks an address byte
  localparam int LAST_BIT      = 7;   // index of the final data bit
  localparam int BIT_DIV_DEF   = 16;  // default clock cycles per serial bit
  localparam int IDLE_BITS     = 10;  // high bit times that make an idle frame
  localparam int BREAK_BITS    = 10;  // low bit times sent as a break
  localparam int RX_DEPTH      = 2;   // entries in the receive buffer
  localparam logic RTS_ON      = 1'b0; // throttle output level that lets data in
  localparam logic RTS_OFF     = 1'b1; // throttle output level that halts the sender
  localparam logic LINE_IDLE   = 1'b1; // idle level of the data line

  // transmit sequencer, gray along idle-start-data-stop
  typedef enum logic [2:0]
  {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h3,
    TX_STOP  = 3'h2,
    TX_BREAK = 3'h6
  } ufx_tx_e;

  // asynchronous receive sequencer
  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } ufx_rx_e;
endpackage

// [core/ufx_stream_if.sv]
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
interface ufx_stream_if #(parameter int W = 8);
  logic         valid;  // word offered
  logic         ready;  // word can be taken
  logic [W-1:0] data;   // the word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [core/ufx_sync2.sv]
// two-flop synchroniser, one chain per bit
`timescale 1ns/1ps
module ufx_sync2 #(
  parameter int W = 2
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  input  wire logic [W-1:0] init_i,
  output wire logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;  // first stage, read only by the second
  logic [W-1:0] sync_ff;  // second stage, safe to use

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      // reset to idle-high keeps a spurious edge out of the logic
      always_ff @(posedge mclk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          meta_ff[g] <= 1'b1;
          sync_ff[g] <= 1'b1;
        end
        else
        begin
          meta_ff[g] <= async_i[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_ff;
  // init_i kept for symmetry of callers; reset value is the idle level
  logic unused_init;
  assign unused_init = ^init_i;
endmodule

// [core/ufx_buf2.sv]
// small receive buffer with valid/ready on both sides
`timescale 1ns/1ps
module ufx_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic   mclk_i,
  input  wire logic   reset_i,
  ufx_stream_if.snk   in_s,
  ufx_stream_if.src   out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW:0] ONE  = (PW+1)'(1);
  localparam logic [PW-1:0] PONE = PW'(1);

  logic [W-1:0]  mem_ff [DEPTH];  // storage words
  logic [PW-1:0] wr_ff;           // write pointer
  logic [PW-1:0] rd_ff;           // read pointer
  logic [PW:0]   cnt_ff;          // words held

  wire push_w = in_s.valid & in_s.ready;
  wire pop_w  = out_s.valid & out_s.ready;

  assign in_s.ready  = (cnt_ff != FULL);
  assign out_s.valid = (cnt_ff != '0);
  assign out_s.data  = mem_ff[rd_ff];

  // pointers and fill level; pointers wrap, depth is a power of two
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push_w)
        wr_ff <= wr_ff + PONE;
      if (pop_w)
        rd_ff <= rd_ff + PONE;
      if (push_w && !pop_w)
        cnt_ff <= cnt_ff + ONE;
      else if (pop_w && !push_w)
        cnt_ff <= cnt_ff - ONE;
    end
  end

  // data words, no reset needed
  always_ff @(posedge mclk_i)
  begin
    if (push_w)
      mem_ff[wr_ff] <= in_s.data;
  end
endmodule

// [core/ufx_ext.sv]
// flow control, mute/wake and synchronous master clock for a serial transceiver
//
// Notes on behaviour
// [R01] throttle enabled and data held: drive throttle high
// [R02] receiver free again: drive throttle low
// [R03] send gate input is active low
// [R04] gate drop mid-frame: finish frame, then stop
// [R05] word written while gated waits for gate
// [R06] gate level change sets sticky flag, optional interrupt
// [R07] wake method 0 selects idle-line wake
// [R08] muted: no receive flags, no receive interrupts
// [R09] idle frame unmutes, idle flag stays clear
// [R10] wake method 1: msb-set byte is address
// [R11] mute writes accepted only with empty buffer
// [R12] mismatching address byte sets mute
// [R13] matching address clears mute, byte delivered
// [R14] synchronous mode is clock master only
// [R15] software keeps other special modes off
// [R16] serial clock quiet when idle or breaking
// [R17] no clock pulses on start, stop bits
// [R18] clock idle level follows polarity setting
// [R19] phase picks first or second edge sampling
// [R20] software changes clock setup only while disabled
// [R21] last-bit pulse setting gates final data clock
// [R22] clock only while transmitting written data
// [R23] synchronous receive samples on own edge
// [R24] software clears gate change flag explicitly
`timescale 1ns/1ps
module ufx_ext #(
  parameter int BIT_DIV = ufx_pkg::BIT_DIV_DEF
) (
  input  wire logic                      mclk_i,
  input  wire logic                      reset_i,
  input  wire logic                      tx_enable_i,
  input  wire logic                      rx_enable_i,
  input  wire logic                      send_break_i,
  input  wire logic                      receive_throttle_enable_i,
  input  wire logic                      send_gate_enable_i,
  input  wire logic                      send_gate_change_irq_enable_i,
  input  wire logic                      send_gate_change_clear_i,
  input  wire logic                      wake_method_i,
  input  wire logic [ufx_pkg::ADDR_W-1:0] node_addr_i,
  input  wire logic                      mute_write_i,
  input  wire logic                      mute_wdata_i,
  input  wire logic                      idle_line_clear_i,
  input  wire logic                      sync_clock_enable_i,
  input  wire logic                      clock_idle_level_i,
  input  wire logic                      clock_sample_edge_i,
  input  wire logic                      last_bit_clock_pulse_i,
  input  wire logic                      tx_valid_i,
  input  wire logic [ufx_pkg::DATA_W-1:0] tx_data_i,
  output wire logic                      tx_ready_o,
  output wire logic                      rx_valid_o,
  output wire logic [ufx_pkg::DATA_W-1:0] rx_data_o,
  input  wire logic                      rx_read_i,
  input  wire logic                      send_gate_n_i,
  output wire logic                      receive_throttle_n_o,
  input  wire logic                      rxd_i,
  output wire logic                      txd_o,
  output wire logic                      serial_clock_out_o,
  output wire logic                      send_gate_change_flag_o,
  output wire logic                      send_gate_irq_o,
  output wire logic                      idle_line_flag_o,
  output wire logic                      receiver_mute_o,
  output wire logic                      tx_busy_o
);
  localparam int DW = ufx_pkg::DATA_W;
  localparam int CW = $clog2(BIT_DIV);
  localparam int IC = ufx_pkg::IDLE_BITS * BIT_DIV;
  localparam int IW = $clog2(IC + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(BIT_DIV - 1);
  localparam logic [CW-1:0] CYC_HALF = CW'(BIT_DIV / 2);
  localparam logic [CW-1:0] CYC_ONE  = CW'(1);
  localparam logic [3:0]    BIT_LAST = 4'(ufx_pkg::LAST_BIT);
  localparam logic [3:0]    BRK_LAST = 4'(ufx_pkg::BREAK_BITS - 1);
  localparam logic [3:0]    BIT_ONE  = 4'h1;
  localparam logic [IW-1:0] IDLE_END = IW'(IC - 1);
  localparam logic [IW-1:0] IDLE_ONE = IW'(1);

  // pin synchronisers: gate input and receive line
  logic gate_s;   // synchronised send gate, low = allowed
  logic rxd_s;    // synchronised receive line
  ufx_sync2 #(.W(2)) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i ({send_gate_n_i, rxd_i}),
    .init_i  ({ufx_pkg::LINE_IDLE, ufx_pkg::LINE_IDLE}),
    .sync_o  ({gate_s, rxd_s})
  );

  // receive buffer streams
  ufx_stream_if #(.W(DW)) rx_in_if ();
  ufx_stream_if #(.W(DW)) rx_out_if ();
  ufx_buf2 #(.W(DW), .DEPTH(ufx_pkg::RX_DEPTH)) u_rxbuf (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .in_s    (rx_in_if),
    .out_s   (rx_out_if)
  );
  assign rx_out_if.ready = rx_read_i;
  assign rx_valid_o      = rx_out_if.valid;
  assign rx_data_o       = rx_out_if.data;

  // ---------------- transmit side ----------------
  ufx_pkg::ufx_tx_e tx_st_ff, nxt_tx_st;   // transmit state
  logic [CW-1:0]   txc_ff;                 // cycle within bit
  logic [3:0]      txb_ff;                 // bit index
  logic [DW-1:0]   txsh_ff;                // outgoing shift word
  logic            txd_ff;                 // registered data pin
  logic            sclk_ff;                // registered clock pin

  // gate is active low; disabled gate always allows
  wire gate_ok_w   = !send_gate_enable_i || !gate_s;                   // [R03]
  // synchronous receive must have room before a frame starts
  wire sync_room_w = !(sync_clock_enable_i && rx_enable_i) || rx_in_if.ready;
  wire tx_idle_w   = (tx_st_ff == ufx_pkg::TX_IDLE);
  // gate looked at only between frames, so a drop lets the frame end
  wire tx_go_w     = tx_idle_w && tx_enable_i && tx_valid_i && gate_ok_w
                     && sync_room_w && !send_break_i;                  // [R04] [R05]
  wire brk_go_w    = tx_idle_w && tx_enable_i && send_break_i;
  wire bit_end_w   = (txc_ff == CYC_LAST);
  wire first_half_w = (txc_ff < CYC_HALF);
  wire mid_tick_w  = (txc_ff == CYC_HALF);
  assign tx_ready_o = tx_go_w;
  assign tx_busy_o  = !tx_idle_w;

  // transmit sequencing
  always_comb
  begin
    nxt_tx_st = tx_st_ff;
    case (tx_st_ff)
      ufx_pkg::TX_IDLE:
        if (brk_go_w)
          nxt_tx_st = ufx_pkg::TX_BREAK;
        else if (tx_go_w)
          nxt_tx_st = ufx_pkg::TX_START;
      ufx_pkg::TX_START:
        if (bit_end_w)
          nxt_tx_st = ufx_pkg::TX_DATA;
      ufx_pkg::TX_DATA:
        if (bit_end_w && txb_ff == BIT_LAST)
          nxt_tx_st = ufx_pkg::TX_STOP;
      ufx_pkg::TX_STOP:
        if (bit_end_w)
          nxt_tx_st = ufx_pkg::TX_IDLE;
      ufx_pkg::TX_BREAK:
        if (bit_end_w && txb_ff == BRK_LAST)
          nxt_tx_st = ufx_pkg::TX_STOP;
      default:
        nxt_tx_st = ufx_pkg::TX_IDLE;
    endcase
  end

  // clock pulse only for data bits, last one optional
  wire pulse_bit_w = sync_clock_enable_i && (tx_st_ff == ufx_pkg::TX_DATA)
                     && ((txb_ff != BIT_LAST) || last_bit_clock_pulse_i); // [R17] [R21] [R22]
  // phase 1 toggles at bit start, phase 0 at mid-bit; sample edge lands mid-bit
  wire clk_act_w   = pulse_bit_w && (clock_sample_edge_i ? first_half_w : !first_half_w); // [R19]
  wire nxt_sclk    = clock_idle_level_i ^ clk_act_w;                  // [R16] [R18]
  wire nxt_txd     = (tx_st_ff == ufx_pkg::TX_DATA) ? txsh_ff[0] :
                     ((tx_st_ff == ufx_pkg::TX_START) || (tx_st_ff == ufx_pkg::TX_BREAK))
                     ? 1'b0 : ufx_pkg::LINE_IDLE;

  // transmit registers
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_st_ff <= ufx_pkg::TX_IDLE;
      txc_ff   <= '0;
      txb_ff   <= '0;
      txsh_ff  <= '0;
      txd_ff   <= 1'b1;
      sclk_ff  <= 1'b0;
    end
    else
    begin
      tx_st_ff <= nxt_tx_st;
      txc_ff   <= (tx_idle_w || bit_end_w) ? '0 : txc_ff + CYC_ONE;
      txd_ff   <= nxt_txd;
      sclk_ff  <= nxt_sclk;                                           // [R14]
      if (tx_go_w)
        txsh_ff <= tx_data_i;
      else if (bit_end_w && tx_st_ff == ufx_pkg::TX_DATA)
        txsh_ff <= txsh_ff >> 1;
      if (nxt_tx_st != tx_st_ff)
        txb_ff <= '0;
      else if (bit_end_w)
        txb_ff <= txb_ff + BIT_ONE;
    end
  end
  assign txd_o              = txd_ff;
  assign serial_clock_out_o = sclk_ff;

  // ---------------- receive side ----------------
  ufx_pkg::ufx_rx_e rx_st_ff, nxt_rx_st;   // async receive state
  logic [CW-1:0]   rxc_ff;                 // cycle counter
  logic [3:0]      rxb_ff;                 // data bit index
  logic [DW-1:0]   rxsh_ff;                // incoming shift word
  logic [IW-1:0]   idc_ff;                 // idle high cycles
  logic            armed_ff;               // line has seen traffic since last idle

  wire async_on_w = rx_enable_i && !sync_clock_enable_i;
  wire rx_tick_w  = (rx_st_ff == ufx_pkg::RX_START) ? (rxc_ff == CYC_HALF) : (rxc_ff == CYC_LAST);
  // synchronous sample taken directly at the generated edge, no oversampling
  wire sync_smp_w = sync_clock_enable_i && rx_enable_i && mid_tick_w
                    && (tx_st_ff == ufx_pkg::TX_DATA);                // [R23] [R22]
  wire async_smp_w = (rx_st_ff == ufx_pkg::RX_DATA) && rx_tick_w;
  wire sync_done_w = sync_clock_enable_i && rx_enable_i && bit_end_w
                     && (tx_st_ff == ufx_pkg::TX_DATA) && (txb_ff == BIT_LAST);
  wire async_done_w = (rx_st_ff == ufx_pkg::RX_STOP) && rx_tick_w && rxd_s;
  wire byte_done_w = sync_done_w || async_done_w;
  wire idle_evt_w  = armed_ff && (rx_st_ff == ufx_pkg::RX_IDLE) && (idc_ff == IDLE_END);

  // async receive sequencing
  always_comb
  begin
    nxt_rx_st = rx_st_ff;
    case (rx_st_ff)
      ufx_pkg::RX_IDLE:
        if (async_on_w && !rxd_s)
          nxt_rx_st = ufx_pkg::RX_START;
      ufx_pkg::RX_START:
        if (rx_tick_w)
          nxt_rx_st = rxd_s ? ufx_pkg::RX_IDLE : ufx_pkg::RX_DATA;
      ufx_pkg::RX_DATA:
        if (rx_tick_w && rxb_ff == BIT_LAST)
          nxt_rx_st = ufx_pkg::RX_STOP;
      ufx_pkg::RX_STOP:
        if (rx_tick_w)
          nxt_rx_st = ufx_pkg::RX_IDLE;
      default:
        nxt_rx_st = ufx_pkg::RX_IDLE;
    endcase
  end

  // receive registers
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_st_ff <= ufx_pkg::RX_IDLE;
      rxc_ff   <= '0;
      rxb_ff   <= '0;
      rxsh_ff  <= '0;
      idc_ff   <= '0;
      armed_ff <= 1'b0;
    end
    else
    begin
      rx_st_ff <= nxt_rx_st;
      rxc_ff   <= (nxt_rx_st != rx_st_ff || rx_tick_w) ? '0 : rxc_ff + CYC_ONE;
      if (nxt_rx_st != rx_st_ff)
        rxb_ff <= '0;
      else if (async_smp_w)
        rxb_ff <= rxb_ff + BIT_ONE;
      if (async_smp_w || sync_smp_w)
        rxsh_ff <= {rxd_s, rxsh_ff[DW-1:1]};
      // idle count restarts on any low level or on a fired idle frame
      idc_ff   <= (!rxd_s || !async_on_w || idle_evt_w) ? '0 : idc_ff + IDLE_ONE;
      if (idle_evt_w)
        armed_ff <= 1'b0;
      else if (rx_st_ff == ufx_pkg::RX_START)
        armed_ff <= 1'b1;
    end
  end

  // ---------------- mute and wake ----------------
  logic mute_ff;       // receiver muted
  logic idle_flag_ff;  // idle line seen while awake

  wire is_addr_w  = wake_method_i && rxsh_ff[ufx_pkg::ADDR_MARK_BIT];   // [R10]
  wire match_w    = (rxsh_ff[ufx_pkg::ADDR_W-1:0] == node_addr_i);
  // muted data bytes vanish without touching any flag
  wire deliver_w  = byte_done_w && (is_addr_w ? match_w : !mute_ff);    // [R08] [R13]
  wire addr_set_w = byte_done_w && is_addr_w && !match_w;
  wire addr_clr_w = byte_done_w && is_addr_w && match_w;
  wire idle_wake_w = idle_evt_w && mute_ff && !wake_method_i;            // [R07] [R09]
  wire sw_mute_ok_w = mute_write_i && !rx_out_if.valid;                  // [R11]
  // hardware events outrank a software write in the same cycle
  wire nxt_mute   = addr_set_w ? 1'b1 :                                  // [R12]
                    (addr_clr_w || idle_wake_w) ? 1'b0 :
                    sw_mute_ok_w ? mute_wdata_i : mute_ff;
  wire nxt_idle_flag = (idle_evt_w && !mute_ff) || (idle_flag_ff && !idle_line_clear_i);

  assign rx_in_if.valid = deliver_w;
  assign rx_in_if.data  = rxsh_ff;

  // mute and idle flag registers
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mute_ff      <= 1'b0;
      idle_flag_ff <= 1'b0;
    end
    else
    begin
      mute_ff      <= nxt_mute;
      idle_flag_ff <= nxt_idle_flag;
    end
  end
  assign receiver_mute_o  = mute_ff;
  assign idle_line_flag_o = idle_flag_ff;

  // ---------------- flow control ----------------
  logic gate_prev_ff;  // last synchronised gate level
  logic gate_flag_ff;  // sticky gate change flag
  logic rts_n_ff;      // throttle output

  // set wins over a clear arriving in the same cycle
  wire gate_chg_w    = send_gate_enable_i && (gate_s != gate_prev_ff);
  wire nxt_gate_flag = gate_chg_w || (gate_flag_ff && !send_gate_change_clear_i); // [R06] [R24]
  // a held word halts the sender; two entries absorb its frame in flight
  wire nxt_rts_n     = (receive_throttle_enable_i && rx_out_if.valid)
                       ? ufx_pkg::RTS_OFF : ufx_pkg::RTS_ON;             // [R01] [R02]

  // flow control registers
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      gate_prev_ff <= 1'b1;
      gate_flag_ff <= 1'b0;
      rts_n_ff     <= ufx_pkg::RTS_ON;
    end
    else
    begin
      gate_prev_ff <= gate_s;
      gate_flag_ff <= nxt_gate_flag;
      rts_n_ff     <= nxt_rts_n;
    end
  end
  assign send_gate_change_flag_o = gate_flag_ff;
  assign send_gate_irq_o         = gate_flag_ff && send_gate_change_irq_enable_i;
  assign receive_throttle_n_o    = rts_n_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_last_bit_quiet;
    (tx_st_ff == ufx_pkg::TX_DATA) && (txb_ff == BIT_LAST) && !last_bit_clock_pulse_i;
  endsequence

  a_rts_throttle: assert property (receive_throttle_enable_i && rx_out_if.valid |=> receive_throttle_n_o) // [R01]
    else $error("throttle not raised while data held");
  a_rts_release: assert property (!rx_out_if.valid |=> !receive_throttle_n_o) // [R02]
    else $error("throttle not released with empty buffer");
  a_gate_hold: assert property (tx_idle_w && send_gate_enable_i && gate_s |=> tx_idle_w) // [R05]
    else $error("frame started while gate inactive");
  a_gate_flag: assert property (send_gate_enable_i && $changed(gate_s) |=> send_gate_change_flag_o) // [R06]
    else $error("gate change flag missed");
  a_mute_silent: assert property (byte_done_w && mute_ff && !is_addr_w |-> !rx_in_if.valid) // [R08]
    else $error("muted byte delivered");
  a_idle_wake: assert property (idle_wake_w |=> !receiver_mute_o && !$rose(idle_line_flag_o)) // [R09]
    else $error("idle wake wrong");
  a_addr_miss: assert property (addr_set_w |=> receiver_mute_o) // [R12]
    else $error("mismatched address left receiver awake");
  a_addr_hit: assert property (addr_clr_w |-> rx_in_if.valid ##1 !receiver_mute_o) // [R13]
    else $error("matched address not taken");
  a_mute_guard: assert property (mute_write_i && rx_out_if.valid && !byte_done_w && !idle_evt_w
                                 |=> $stable(receiver_mute_o)) // [R11]
    else $error("mute write taken with data held");
  a_clk_frame: assert property (tx_st_ff != ufx_pkg::TX_DATA |=> serial_clock_out_o == $past(clock_idle_level_i)) // [R17]
    else $error("clock pulse outside data bits");
  a_last_bit: assert property (s_last_bit_quiet |=> serial_clock_out_o == $past(clock_idle_level_i)) // [R21]
    else $error("last bit pulse not suppressed");
endmodule

// [testbench/ufx_peer.sv]
// behavioural peer transmitter feeding the block's receive and gate pins
`timescale 1ns/1ps
module ufx_peer #(
  parameter int BIT_DIV = 20
) (
  input  wire logic mclk_i,
  input  wire logic gate_hold_i,
  output logic      rxd_o,
  output logic      send_gate_n_o
);
  initial rxd_o = 1'b1;                // line rests high between frames
  assign send_gate_n_o = gate_hold_i;  // low lets the block send
  // one frame: start low, eight bits lsb first, stop high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++)
    begin
      rxd_o <= f[k];
      repeat (BIT_DIV) @(posedge mclk_i);
    end
  endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the serial extension block
`timescale 1ns/1ps
module tb_top;
  localparam int BD = 20;  // 80 ns bit time at a 4 ns clock
  logic mclk_i = 1'b0, reset_i = 1'b1, en = 1'b1, gate_en = 1'b0, irq_en = 1'b0;
  logic gate_clr = 1'b0, wake = 1'b0, mute_wr = 1'b0, mute_wd = 1'b0, idle_clr = 1'b0;
  logic sync_en = 1'b0, pol = 1'b0, lbp = 1'b0, tx_valid = 1'b0, rx_read = 1'b0, hold = 1'b0;
  logic brk = 1'b0, rte = 1'b1, pha = 1'b0;  // break request, throttle enable, clock phase
  logic [3:0] node    = 4'h3;  // own node address
  logic [7:0] tx_data = 8'h00;
  wire rxd, gate_n, thr_n, txd, scko, flag, irq, idle_f, mute, busy, tx_rdy, rx_vld;
  wire [7:0] rx_data;
  int mismatches = 0;
  int n_compared = 0;
  always #2 mclk_i = ~mclk_i;  // 250 MHz
  ufx_ext #(.BIT_DIV(BD)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .tx_enable_i(en),
    .rx_enable_i(en), .send_break_i(brk), .receive_throttle_enable_i(rte),
    .send_gate_enable_i(gate_en), .send_gate_change_irq_enable_i(irq_en),
    .send_gate_change_clear_i(gate_clr), .wake_method_i(wake), .node_addr_i(node),
    .mute_write_i(mute_wr), .mute_wdata_i(mute_wd), .idle_line_clear_i(idle_clr),
    .sync_clock_enable_i(sync_en), .clock_idle_level_i(pol), .clock_sample_edge_i(pha),
    .last_bit_clock_pulse_i(lbp), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_rdy), .rx_valid_o(rx_vld), .rx_data_o(rx_data), .rx_read_i(rx_read),
    .send_gate_n_i(gate_n), .receive_throttle_n_o(thr_n), .rxd_i(rxd), .txd_o(txd),
    .serial_clock_out_o(scko), .send_gate_change_flag_o(flag), .send_gate_irq_o(irq),
    .idle_line_flag_o(idle_f), .receiver_mute_o(mute), .tx_busy_o(busy));
  ufx_peer #(.BIT_DIV(BD)) peer (.mclk_i(mclk_i), .gate_hold_i(hold), .rxd_o(rxd),
    .send_gate_n_o(gate_n));
  // inputs move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic pop();
    rx_read = 1'b1;
    cyc(1);
    rx_read = 1'b0;
    cyc(2);
  endtask
  task automatic mute_set(input logic v);
    mute_wd = v;
    mute_wr = 1'b1;
    cyc(1);
    mute_wr = 1'b0;
    cyc(2);
  endtask
  // clock setup only moves with both directions disabled; phase follows polarity here
  // other special modes have no pins on this block, so they stay off
  task automatic setup(input logic s, input logic p, input logic l);
    en = 1'b0;
    sync_en = s;
    pol = p;
    pha = p;
    lbp = l;
    cyc(2);
    en = 1'b1;
    cyc(2);
  endtask
  // offers a word, then walks its frame; bounded wait for the start bit
  task automatic tx_frame(input logic [7:0] b, output logic [7:0] got, output int pl, bad);
    int i;
    logic prev;
    tx_data = b;
    tx_valid = 1'b1;
    for (i = 0; i < 2000 && txd !== 1'b0; i++) cyc(1);
    if (i == 2000)
    begin
      mismatches++;
      tally_and_finish();
    end
    tx_valid = 1'b0;
    pl = 0;
    bad = 0;
    prev = scko;
    for (int c = 1; c < 10 * BD; c++)
    begin
      cyc(1);
      if (c % BD == BD / 2 && c > BD && c < 9 * BD) got[c / BD - 1] = txd;
      if ((c < BD || c >= 9 * BD) && scko !== pol) bad++;  // start/stop quiet
      if (prev === pol && scko !== pol) pl++;               // count pulses
      prev = scko;
    end
  endtask
  task automatic t_rx();
    peer.send(8'h5a);
    cyc(2);
    chk(rx_data, 8'h5a);
    chk(thr_n, 1'b1);
    mute_set(1'b1);
    chk(mute, 1'b0);
    pop();
    chk(thr_n, 1'b0);
  endtask
  // gate drops mid-frame, then a word waits for it
  task automatic t_gate();
    logic [7:0] g;
    int p, b;
    gate_en = 1'b1;
    irq_en = 1'b1;
    fork
      tx_frame(8'ha5, g, p, b);
      begin
        cyc(3 * BD);
        hold = 1'b1;
      end
    join
    chk(g, 8'ha5);
    tx_data = 8'h3c;
    tx_valid = 1'b1;
    cyc(40);
    chk(busy, 1'b0);
    chk(flag, 1'b1);
    chk(irq, 1'b1);
    hold = 1'b0;
    tx_frame(8'h3c, g, p, b);
    chk(g, 8'h3c);
    chk(8'(p), 8'h00);
    gate_clr = 1'b1;
    cyc(1);
    gate_clr = 1'b0;
    cyc(1);
    chk(flag, 1'b0);
  endtask
  task automatic t_sync();
    logic [7:0] g;
    int p, b;
    setup(1'b1, 1'b0, 1'b0);
    chk(scko, 1'b0);
    tx_frame(8'h96, g, p, b);
    chk(g, 8'h96);
    chk(8'(p), 8'h07);
    chk(8'(b), 8'h00);
    cyc(2);
    chk(rx_data, 8'hff);
    pop();
    setup(1'b1, 1'b1, 1'b1);
    chk(scko, 1'b1);
    tx_frame(8'h69, g, p, b);
    chk(8'(p), 8'h08);
    chk(8'(b), 8'h00);
    cyc(2);
    pop();
    // a break holds the line low with the clock parked at its idle level
    brk = 1'b1;
    cyc(5 * BD);
    chk(txd, 1'b0);
    chk(scko, pol);
    brk = 1'b0;
    cyc(12 * BD);
    chk(busy, 1'b0);
  endtask
  task automatic t_addr();
    setup(1'b0, 1'b0, 1'b0);
    wake = 1'b1;
    mute_set(1'b1);
    chk(mute, 1'b1);
    peer.send(8'h83);
    cyc(2);
    chk(mute, 1'b0);
    chk(rx_data, 8'h83);
    pop();
    peer.send(8'h85);
    cyc(2);
    chk(mute, 1'b1);
    idle_clr = 1'b1;
    cyc(1);
    idle_clr = 1'b0;
    peer.send(8'h11);
    cyc(2);
    chk(rx_vld, 1'b0);
    wake = 1'b0;
    cyc(12 * BD);
    chk(mute, 1'b0);
    chk(idle_f, 1'b0);
  endtask
  initial
  begin
    cyc(20);
    reset_i = 1'b0;
    cyc(3);
    t_rx();
    t_gate();
    t_sync();
    t_addr();
    tally_and_finish();
  end
endmodule
